// *** core/htd_core.sv ***
module htd_core (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic HOST_SUP_32,
    input wire logic CSR_WR_EN,
    input wire htd_pkg::htd_sel_t CSR_WR_SEL,
    input wire logic [63:0] CSR_WDATA,
    input wire htd_pkg::htd_sel_t CSR_RD_SEL,
    output logic [63:0] CSR_RDATA,
    input wire logic TRAP_VALID,
    input wire logic TRAP_AT_HOST,
    input wire logic VIRT_BEFORE_TRAP,
    input wire logic [5:0] TRAP_CAUSE,
    output logic TRAP_TO_GUEST,
    input wire logic [1:0] CUR_PRIV,
    input wire logic CUR_VIRT,
    input wire logic SUP_GLOBAL_IE,
    input wire logic [63:0] SUP_PENDING,
    input wire logic [63:0] SUP_ENABLE,
    input wire logic [63:0] GUEST_LINE_PENDING,
    input wire logic [63:0] GUEST_LINE_ENABLE,
    input wire logic [5:0] GUEST_EXT_SOURCE_SELECT,
    input wire logic PLAT_GUEST_EXT_IRQ,
    input wire logic PLAT_GUEST_TIMER_IRQ,
    output logic HOST_IRQ_TAKE,
    output logic [5:0] HOST_IRQ_CODE,
    output logic GUEST_IRQ_PENDING,
    output logic [5:0] GUEST_IRQ_CODE,
    output logic [63:0] GUEST_PENDING_VIEW
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // fixed host priority among the standard causes, then lowest platform cause
    function automatic logic [6:0] pick_host(input logic [63:0] cand);
        logic [6:0] res;
        res = 7'h00;
        for (int i = 63; i >= int'(htd_pkg::FIRST_PLATFORM_CAUSE); i--) begin
            if (cand[i]) begin
                res = {1'b1, 6'(i)};
            end
        end
        if (cand[htd_pkg::BIT_LCOF]) res = {1'b1, 6'(htd_pkg::BIT_LCOF)};
        if (cand[htd_pkg::BIT_GTI]) res = {1'b1, 6'(htd_pkg::BIT_GTI)};
        if (cand[htd_pkg::BIT_GSI]) res = {1'b1, 6'(htd_pkg::BIT_GSI)};
        if (cand[htd_pkg::BIT_GEI]) res = {1'b1, 6'(htd_pkg::BIT_GEI)};
        if (cand[htd_pkg::BIT_GUEST_EXT_SUMMARY_IRQ]) res = {1'b1, 6'(htd_pkg::BIT_GUEST_EXT_SUMMARY_IRQ)};
        if (cand[htd_pkg::BIT_STI]) res = {1'b1, 6'(htd_pkg::BIT_STI)};
        if (cand[htd_pkg::BIT_SSI]) res = {1'b1, 6'(htd_pkg::BIT_SSI)};
        if (cand[htd_pkg::BIT_SEI]) res = {1'b1, 6'(htd_pkg::BIT_SEI)};
        return res;
    endfunction : pick_host

    // guest-level bits move down one position; platform causes pass unchanged
    function automatic logic [63:0] to_guest(input logic [63:0] fwd);
        logic [63:0] res;
        res = {fwd[63:16], 16'h0000};
        res[htd_pkg::BIT_SEI] = fwd[htd_pkg::BIT_GEI];
        res[htd_pkg::BIT_STI] = fwd[htd_pkg::BIT_GTI];
        res[htd_pkg::BIT_SSI] = fwd[htd_pkg::BIT_GSI];
        return res;
    endfunction : to_guest

    // ------------------------------------------------------------------
    // platform input synchronisers
    // ------------------------------------------------------------------
    logic ext_meta_q;
    logic ext_sync_q;
    logic tmr_meta_q;
    logic tmr_sync_q;

    // two flops per platform line
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            tmr_meta_q <= 1'b0;
            tmr_sync_q <= 1'b0;
        end else if (CE) begin
            ext_meta_q <= PLAT_GUEST_EXT_IRQ;
            ext_sync_q <= ext_meta_q;
            tmr_meta_q <= PLAT_GUEST_TIMER_IRQ;
            tmr_sync_q <= tmr_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------------
    logic [63:0] exc_fwd_q;
    logic [63:0] exc_fwd_d;
    logic [63:0] irq_fwd_q;
    logic [63:0] irq_fwd_d;
    logic [63:0] inject_q;
    logic [63:0] inject_d;
    logic [63:0] enable_q;
    logic [63:0] enable_d;
    wire logic [63:0] exc_wmask;
    wire logic [63:0] width_mask;
    wire logic wr_exc;
    wire logic wr_exc_upper;
    wire logic wr_irq;
    wire logic wr_inject;
    wire logic wr_pending;
    wire logic wr_enable;

    // alignment bit only writable with 32-bit instruction alignment
    assign exc_wmask = htd_pkg::EXC_FWD_FIXED_MASK
        | ((htd_pkg::INSTR_ALIGNMENT_BITS == 32) ? htd_pkg::EXC_FWD_ALIGN_BIT
                                                 : 64'h0000_0000_0000_0000);
    assign width_mask = HOST_SUP_32 ? htd_pkg::LOW_HALF_MASK : ~64'h0000_0000_0000_0000;
    assign wr_exc = CSR_WR_EN && (CSR_WR_SEL == htd_pkg::HTD_SEL_EXC_FWD);
    assign wr_exc_upper = CSR_WR_EN && HOST_SUP_32
        && (CSR_WR_SEL == htd_pkg::HTD_SEL_EXC_FWD_UPPER);
    assign wr_irq = CSR_WR_EN && (CSR_WR_SEL == htd_pkg::HTD_SEL_IRQ_FWD);
    assign wr_inject = CSR_WR_EN && (CSR_WR_SEL == htd_pkg::HTD_SEL_INJECT);
    assign wr_pending = CSR_WR_EN && (CSR_WR_SEL == htd_pkg::HTD_SEL_PENDING);
    assign wr_enable = CSR_WR_EN && (CSR_WR_SEL == htd_pkg::HTD_SEL_ENABLE);

    // next values: a low-half write at 32 bits keeps the upper half
    always_comb begin
        exc_fwd_d = exc_fwd_q;
        if (wr_exc) begin
            exc_fwd_d = ((CSR_WDATA & width_mask) | (exc_fwd_q & ~width_mask)) & exc_wmask;
        end else if (wr_exc_upper) begin
            exc_fwd_d = {CSR_WDATA[31:0], exc_fwd_q[31:0]} & exc_wmask;
        end
        irq_fwd_d = wr_irq ? (CSR_WDATA & htd_pkg::IRQ_FWD_MASK) : irq_fwd_q;
        inject_d = inject_q;
        if (wr_inject) begin
            inject_d = CSR_WDATA & htd_pkg::INJECT_MASK;
        end else if (wr_pending) begin
            // guest software bit shared with the pending register
            inject_d = (inject_q & ~htd_pkg::PENDING_WR_MASK)
                | (CSR_WDATA & htd_pkg::PENDING_WR_MASK);
        end
        enable_d = wr_enable ? (CSR_WDATA & htd_pkg::ENABLE_MASK) : enable_q;
    end

    // control registers
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            exc_fwd_q <= htd_pkg::EXC_FWD_RESET;
            irq_fwd_q <= htd_pkg::IRQ_FWD_RESET;
            inject_q <= htd_pkg::INJECT_RESET;
            enable_q <= htd_pkg::ENABLE_RESET;
        end else if (CE) begin
            exc_fwd_q <= exc_fwd_d;
            irq_fwd_q <= irq_fwd_d;
            inject_q <= inject_d;
            enable_q <= enable_d;
        end
    end

    // ------------------------------------------------------------------
    // pending computation
    // ------------------------------------------------------------------
    wire logic [63:0] line_pend;
    wire logic [63:0] line_en;
    wire logic sel_line;
    wire logic summary_pend;
    wire logic guest_ext_pend;
    wire logic guest_tmr_pend;
    wire logic guest_sw_pend;
    wire logic [63:0] hyp_pending;
    logic [63:0] hyp_pending_c;

    // only lines one to the line count take part
    assign line_pend = GUEST_LINE_PENDING & htd_pkg::LINE_MASK;
    assign line_en = GUEST_LINE_ENABLE & htd_pkg::LINE_MASK;
    assign sel_line = (GUEST_EXT_SOURCE_SELECT != 6'h00)
        && line_pend[GUEST_EXT_SOURCE_SELECT];
    assign summary_pend = |(line_pend & line_en);
    assign guest_ext_pend = inject_q[htd_pkg::BIT_GEI] | sel_line | ext_sync_q;
    assign guest_tmr_pend = inject_q[htd_pkg::BIT_GTI] | tmr_sync_q;
    assign guest_sw_pend = inject_q[htd_pkg::BIT_GSI];

    // hyp pending image; the supervisor-level positions 1, 5 and 9 are never set
    always_comb begin
        hyp_pending_c = 64'h0000_0000_0000_0000;
        hyp_pending_c[htd_pkg::BIT_GUEST_EXT_SUMMARY_IRQ] = summary_pend;
        hyp_pending_c[htd_pkg::BIT_GEI] = guest_ext_pend;
        hyp_pending_c[htd_pkg::BIT_GTI] = guest_tmr_pend;
        hyp_pending_c[htd_pkg::BIT_GSI] = guest_sw_pend;
    end
    assign hyp_pending = hyp_pending_c;

    // ------------------------------------------------------------------
    // trap and interrupt routing
    // ------------------------------------------------------------------
    wire logic mode_allows;
    wire logic [63:0] active;
    wire logic [63:0] host_cand;
    wire logic [63:0] guest_fwd;
    wire logic [6:0] host_pick;
    wire logic [6:0] guest_pick;
    wire logic trap_fwd;

    // host supervisor with global enable, or any less privileged mode
    assign mode_allows = (!CUR_VIRT && (CUR_PRIV == htd_pkg::PRIV_SUP) && SUP_GLOBAL_IE)
        || CUR_VIRT || (CUR_PRIV == htd_pkg::PRIV_USER);
    assign active = (SUP_PENDING & SUP_ENABLE) | (hyp_pending & enable_q);
    assign host_cand = mode_allows ? (active & ~irq_fwd_q) : 64'h0000_0000_0000_0000;
    assign guest_fwd = to_guest(active & irq_fwd_q);
    assign host_pick = pick_host(host_cand);
    assign guest_pick = pick_host(guest_fwd);
    assign trap_fwd = TRAP_VALID && TRAP_AT_HOST && VIRT_BEFORE_TRAP
        && exc_fwd_q[TRAP_CAUSE];

    // decisions re-evaluated every cycle in which the clock enable is high
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            TRAP_TO_GUEST <= 1'b0;
            HOST_IRQ_TAKE <= 1'b0;
            HOST_IRQ_CODE <= htd_pkg::CAUSE_RESET;
            GUEST_IRQ_PENDING <= 1'b0;
            GUEST_IRQ_CODE <= htd_pkg::CAUSE_RESET;
            GUEST_PENDING_VIEW <= 64'h0000_0000_0000_0000;
        end else if (CE) begin
            TRAP_TO_GUEST <= trap_fwd;
            HOST_IRQ_TAKE <= host_pick[6];
            HOST_IRQ_CODE <= host_pick[5:0];
            GUEST_IRQ_PENDING <= guest_pick[6];
            GUEST_IRQ_CODE <= guest_pick[5:0];
            GUEST_PENDING_VIEW <= guest_fwd;
        end
    end

    // ------------------------------------------------------------------
    // register read
    // ------------------------------------------------------------------
    logic [63:0] rd_c;

    // unselected or absent registers read zero
    always_comb begin
        case (CSR_RD_SEL)
            htd_pkg::HTD_SEL_EXC_FWD: rd_c = exc_fwd_q & width_mask;
            htd_pkg::HTD_SEL_EXC_FWD_UPPER: begin
                rd_c = HOST_SUP_32 ? {32'h0000_0000, exc_fwd_q[63:32]}
                                   : 64'h0000_0000_0000_0000;
            end
            htd_pkg::HTD_SEL_IRQ_FWD: rd_c = irq_fwd_q;
            htd_pkg::HTD_SEL_INJECT: rd_c = inject_q;
            htd_pkg::HTD_SEL_PENDING: rd_c = hyp_pending;
            htd_pkg::HTD_SEL_ENABLE: rd_c = enable_q;
            default: rd_c = 64'h0000_0000_0000_0000;
        endcase
    end

    // registered read data
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            CSR_RDATA <= 64'h0000_0000_0000_0000;
        end else if (CE) begin
            CSR_RDATA <= rd_c;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    property p_fixed_zero;
        exc_fwd_q[11:9] == 3'h0 && exc_fwd_q[16] == 1'b0 && exc_fwd_q[23:20] == 4'h0;
    endproperty
    a_fixed_zero: assert property (p_fixed_zero)
        else $error("exception forward reserved bit set");

    property p_exc_write;
        CE && wr_exc && !HOST_SUP_32 |=> exc_fwd_q[19:0] == ($past(CSR_WDATA[19:0]) & 20'hC_B1FF);
    endproperty
    a_exc_write: assert property (p_exc_write)
        else $error("exception forward write mismatch");

    property p_irq_fwd_bits;
        (irq_fwd_q & ~htd_pkg::IRQ_FWD_MASK) == 64'h0000_0000_0000_0000;
    endproperty
    a_irq_fwd_bits: assert property (p_irq_fwd_bits)
        else $error("interrupt forward mask holds a fixed-zero bit");

    property p_trap_fwd;
        CE && TRAP_VALID && TRAP_AT_HOST && VIRT_BEFORE_TRAP && exc_fwd_q[TRAP_CAUSE]
            |=> TRAP_TO_GUEST;
    endproperty
    a_trap_fwd: assert property (p_trap_fwd)
        else $error("delegated trap not routed to guest");

    property p_no_host_when_fwd;
        CE && host_pick[6] |-> !irq_fwd_q[host_pick[5:0]];
    endproperty
    a_no_host_when_fwd: assert property (p_no_host_when_fwd)
        else $error("forwarded interrupt chosen for host");

    property p_summary;
        CE |-> hyp_pending[htd_pkg::BIT_GUEST_EXT_SUMMARY_IRQ]
            == |(GUEST_LINE_PENDING & GUEST_LINE_ENABLE & htd_pkg::LINE_MASK);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary pending bit wrong");

    property p_sw_alias;
        CE && wr_pending |=> hyp_pending[htd_pkg::BIT_GSI] == $past(CSR_WDATA[2]);
    endproperty
    a_sw_alias: assert property (p_sw_alias)
        else $error("software pending alias not updated");

    property p_sei_first;
        CE && host_cand[htd_pkg::BIT_SEI] |=> HOST_IRQ_CODE == 6'h09 && HOST_IRQ_TAKE;
    endproperty
    a_sei_first: assert property (p_sei_first)
        else $error("supervisor external not highest priority");

    property p_guest_translate;
        CE && guest_fwd[htd_pkg::BIT_SEI] |=> GUEST_IRQ_CODE == 6'h09;
    endproperty
    a_guest_translate: assert property (p_guest_translate)
        else $error("guest external not presented as code nine");

    property p_inject_bits;
        (inject_q & ~htd_pkg::INJECT_MASK) == 64'h0000_0000_0000_0000;
    endproperty
    a_inject_bits: assert property (p_inject_bits)
        else $error("injection register holds a fixed-zero bit");

    property p_enable_bits;
        (enable_q & ~htd_pkg::ENABLE_MASK) == 64'h0000_0000_0000_0000;
    endproperty
    a_enable_bits: assert property (p_enable_bits)
        else $error("hyp enable register holds a fixed-zero bit");

    property p_mode_blocks;
        CE && !mode_allows |=> !HOST_IRQ_TAKE;
    endproperty
    a_mode_blocks: assert property (p_mode_blocks)
        else $error("host interrupt taken in a mode that forbids it");

    property p_guest_ext_src;
        CE && (inject_q[htd_pkg::BIT_GEI] || ext_sync_q) |-> hyp_pending[htd_pkg::BIT_GEI];
    endproperty
    a_guest_ext_src: assert property (p_guest_ext_src)
        else $error("guest external source not reflected in pending");

    property p_trap_blocked;
        CE && !VIRT_BEFORE_TRAP |=> !TRAP_TO_GUEST;
    endproperty
    a_trap_blocked: assert property (p_trap_blocked)
        else $error("trap routed to guest although not virtualized before");

    c_trap_fwd: cover property (CE && trap_fwd);
    c_host_take: cover property (CE && host_pick[6] && host_pick[5:0] == 6'h0C);
    c_guest_fwd: cover property (CE && guest_pick[6]);
    c_summary: cover property (CE && hyp_pending[htd_pkg::BIT_GUEST_EXT_SUMMARY_IRQ] && enable_q[htd_pkg::BIT_GUEST_EXT_SUMMARY_IRQ]);
endmodule : htd_core

// *** core/htd_pkg.sv ***
package htd_pkg;
    // --------------------------------------------------------------
    // register selects and widths
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        HTD_SEL_NONE,
        HTD_SEL_EXC_FWD,
        HTD_SEL_EXC_FWD_UPPER,
        HTD_SEL_IRQ_FWD,
        HTD_SEL_INJECT,
        HTD_SEL_PENDING,
        HTD_SEL_ENABLE
    } htd_sel_t;

    localparam int unsigned REG_W = 64;
    localparam int unsigned HALF_W = 32;
    localparam int unsigned CAUSE_W = 6;
    localparam int unsigned GUEST_LINE_COUNT = 8;  // implemented guest external lines
    localparam int unsigned SELECT_W = 6;
    localparam int unsigned INSTR_ALIGNMENT_BITS = 32;

    // --------------------------------------------------------------
    // interrupt bit positions
    // --------------------------------------------------------------
    localparam int unsigned BIT_SSI = 1;
    localparam int unsigned BIT_GSI = 2;
    localparam int unsigned BIT_STI = 5;
    localparam int unsigned BIT_GTI = 6;
    localparam int unsigned BIT_SEI = 9;
    localparam int unsigned BIT_GEI = 10;
    localparam int unsigned BIT_GUEST_EXT_SUMMARY_IRQ = 12;
    localparam int unsigned BIT_LCOF = 13;
    localparam int unsigned FIRST_PLATFORM_CAUSE = 16;

    // --------------------------------------------------------------
    // writable masks and reset values
    // --------------------------------------------------------------
    localparam logic [63:0] EXC_FWD_FIXED_MASK = 64'h0000_0000_000C_B1FE;
    localparam logic [63:0] EXC_FWD_ALIGN_BIT = 64'h0000_0000_0000_0001;
    localparam logic [63:0] IRQ_FWD_MASK = 64'h0000_0000_0000_0444;
    localparam logic [63:0] INJECT_MASK = 64'h0000_0000_0000_0444;
    localparam logic [63:0] ENABLE_MASK = 64'h0000_0000_0000_1444;
    localparam logic [63:0] PENDING_WR_MASK = 64'h0000_0000_0000_0004;
    localparam logic [63:0] LOW_HALF_MASK = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] LINE_MASK = 64'h0000_0000_0000_01FE;
    localparam logic [63:0] EXC_FWD_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] IRQ_FWD_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] INJECT_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ENABLE_RESET = 64'h0000_0000_0000_0000;
    localparam logic [5:0] CAUSE_RESET = 6'h00;

    // --------------------------------------------------------------
    // privilege encodings of the current mode
    // --------------------------------------------------------------
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_SUP = 2'h1;
    localparam logic [1:0] PRIV_MACH = 2'h3;
endpackage : htd_pkg

// *** tb/htd_hart_model.sv ***
// ----------------------------------------------------------------
// hart side interrupt sources and supervisor pair
// ----------------------------------------------------------------
module htd_hart_model (
    input wire logic clock,
    input wire logic upd,
    input wire logic [63:0] seed,
    output logic [63:0] sup_pending,
    output logic [63:0] sup_enable,
    output logic [63:0] line_pending,
    output logic [63:0] line_enable,
    output logic plat_ext,
    output logic plat_timer
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet sources until the bench asks for new levels
    initial begin
        {sup_pending, sup_enable, line_pending, line_enable, plat_ext, plat_timer} = '0;
    end
    // new levels land at the falling edge, away from the sampling edge
    always @(negedge clock) begin
        if (upd) begin
            sup_pending <= seed & 64'h0000_0000_0000_2222;
            sup_enable <= (seed >> 16) & 64'h0000_0000_0000_2222;
            line_pending <= (seed >> 32) & htd_pkg::LINE_MASK;
            line_enable <= (seed >> 40) & htd_pkg::LINE_MASK;
            plat_ext <= seed[60];
            plat_timer <= seed[61];
        end
    end
endmodule : htd_hart_model

// *** tb/tb_hyp_trap_delegation_and_virtual_irq.sv ***
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    $display("unexpected %s expected %h seen %h", nm, exp, got); err_total++; end end

module tb_hyp_trap_delegation_and_virtual_irq;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    localparam int CYCLE_LIMIT = 20000;
    localparam logic [63:0] EXC_EFF = htd_pkg::EXC_FWD_FIXED_MASK | htd_pkg::EXC_FWD_ALIGN_BIT;
    logic clock, resetn, hsup32, wr_en, tvalid, tat_host, tvirt, virt, sie, upd, ce;
    logic to_guest, htake, gpend, pext, ptim, ok, e;
    htd_pkg::htd_sel_t wr_sel, rd_sel;
    logic [63:0] wdata, rdata, sp, se, lp, le, gview, seed, v, r1, r2, r3, r4, hp, pend;
    logic [5:0] tcause, gsel, hcode, gcode;
    logic [6:0] eh;
    logic [1:0] priv;
    logic [31:0] lfsr;
    int err_total, compares, cycles;
    htd_pkg::htd_sel_t sels[6] = '{htd_pkg::HTD_SEL_EXC_FWD, htd_pkg::HTD_SEL_EXC_FWD_UPPER,
        htd_pkg::HTD_SEL_IRQ_FWD, htd_pkg::HTD_SEL_INJECT, htd_pkg::HTD_SEL_PENDING,
        htd_pkg::HTD_SEL_ENABLE};
    logic [63:0] masks[6] = '{EXC_EFF, 64'h0, htd_pkg::IRQ_FWD_MASK, htd_pkg::INJECT_MASK,
        64'h0000_0000_0000_0444, htd_pkg::ENABLE_MASK};
    int ks[3] = '{10, 6, 2};

    htd_hart_model hm (.clock(clock), .upd(upd), .seed(seed), .sup_pending(sp),
        .sup_enable(se), .line_pending(lp), .line_enable(le), .plat_ext(pext),
        .plat_timer(ptim));
    htd_core uut (.CLOCK(clock), .RESETN(resetn), .CE(ce), .HOST_SUP_32(hsup32),
        .CSR_WR_EN(wr_en), .CSR_WR_SEL(wr_sel), .CSR_WDATA(wdata), .CSR_RD_SEL(rd_sel),
        .CSR_RDATA(rdata), .TRAP_VALID(tvalid), .TRAP_AT_HOST(tat_host),
        .VIRT_BEFORE_TRAP(tvirt), .TRAP_CAUSE(tcause), .TRAP_TO_GUEST(to_guest),
        .CUR_PRIV(priv), .CUR_VIRT(virt), .SUP_GLOBAL_IE(sie), .SUP_PENDING(sp),
        .SUP_ENABLE(se), .GUEST_LINE_PENDING(lp), .GUEST_LINE_ENABLE(le),
        .GUEST_EXT_SOURCE_SELECT(gsel), .PLAT_GUEST_EXT_IRQ(pext),
        .PLAT_GUEST_TIMER_IRQ(ptim), .HOST_IRQ_TAKE(htake), .HOST_IRQ_CODE(hcode),
        .GUEST_IRQ_PENDING(gpend), .GUEST_IRQ_CODE(gcode), .GUEST_PENDING_VIEW(gview));

    // ----------------------------------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // a hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == CYCLE_LIMIT) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    function automatic logic [63:0] rnd64();
        logic [63:0] r;
        for (int i = 0; i < 64; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            r[i] = lfsr[0];
        end
        return r;
    endfunction : rnd64
    task automatic wr(input htd_pkg::htd_sel_t s, input logic [63:0] d);
        @(negedge clock);
        wr_en = 1'b1;
        wr_sel = s;
        wdata = d;
        @(negedge clock);
        wr_en = 1'b0;
    endtask : wr
    task automatic rd(input htd_pkg::htd_sel_t s, output logic [63:0] d);
        @(negedge clock);
        rd_sel = s;
        @(negedge clock);
        d = rdata;
    endtask : rd
    // guest level pending set as the hyp pending register shows it
    function automatic logic [63:0] exp_hip(input logic [63:0] inj);
        logic sg, ge;
        sg = |(lp & le);
        ge = inj[10] | (gsel != 6'h0 && lp[gsel]) | pext;
        return {51'h0, sg, 1'b0, ge, 3'h0, inj[6] | ptim, 3'h0, inj[2], 2'h0};
    endfunction : exp_hip
    // highest ranked host interrupt
    function automatic logic [6:0] exp_host(input logic [63:0] p, input logic en);
        int order[8] = '{9, 1, 5, 12, 10, 2, 6, 13};
        for (int i = 0; i < 8; i++) begin
            if (en && p[order[i]]) return {1'b1, 6'(order[i])};
        end
        return 7'h00;
    endfunction : exp_host

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {resetn, hsup32, wr_en, tvalid, tat_host, tvirt, virt, sie, upd} = '0;
        wr_sel = htd_pkg::HTD_SEL_NONE;
        rd_sel = htd_pkg::HTD_SEL_NONE;
        {wdata, seed, tcause, gsel, priv} = '0;
        lfsr = 32'h0000_46CC;
        ce = 1'b1;
        repeat (16) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        // reset values of all registers, then writable bit masks
        for (int i = 0; i < 6; i++) begin
            rd(sels[i], v);
            `CHK("reset value", 64'h0, v)
        end
        for (int i = 0; i < 6; i++) begin
            if (i != 4) wr(sels[i], '1);
        end
        for (int i = 0; i < 6; i++) begin
            rd(sels[i], v);
            `CHK("writable mask", masks[i], v)
        end
        // soft pending alias cleared through either register
        wr(htd_pkg::HTD_SEL_PENDING, 64'h0);
        rd(htd_pkg::HTD_SEL_INJECT, v);
        `CHK("inject after pending clear", 64'h0000_0000_0000_0440, v)
        wr(htd_pkg::HTD_SEL_INJECT, 64'h0);
        rd(htd_pkg::HTD_SEL_PENDING, v);
        `CHK("pending after inject clear", 64'h0, v)
        // narrow host width: upper alias, low half kept
        hsup32 = 1'b1;
        wr(htd_pkg::HTD_SEL_EXC_FWD_UPPER, '1);
        rd(htd_pkg::HTD_SEL_EXC_FWD_UPPER, v);
        `CHK("upper alias", 64'h0, v)
        rd(htd_pkg::HTD_SEL_EXC_FWD, v);
        `CHK("low half kept", EXC_EFF, v)
        hsup32 = 1'b0;
        // a write while the clock enable is low is lost
        ce = 1'b0;
        wr(htd_pkg::HTD_SEL_INJECT, 64'h0000_0000_0000_0444);
        ce = 1'b1;
        rd(htd_pkg::HTD_SEL_INJECT, v);
        `CHK("write while frozen", 64'h0, v)
        // each guest code forwarded and translated, then taken at host
        foreach (ks[j]) begin
            wr(htd_pkg::HTD_SEL_IRQ_FWD, 64'h1 << ks[j]);
            wr(htd_pkg::HTD_SEL_INJECT, 64'h1 << ks[j]);
            wr(htd_pkg::HTD_SEL_ENABLE, 64'h1 << ks[j]);
            repeat (4) @(negedge clock);
            `CHK("forwarded not at host", 1'b0, htake)
            `CHK("guest pending", 1'b1, gpend)
            `CHK("guest code", 6'(ks[j] - 1), gcode)
            `CHK("guest view", 64'h1 << (ks[j] - 1), gview)
            wr(htd_pkg::HTD_SEL_IRQ_FWD, 64'h0);
            repeat (4) @(negedge clock);
            `CHK("host take", 1'b1, htake)
            `CHK("host code", 6'(ks[j]), hcode)
        end
        // random sources, masks and modes
        for (int i = 0; i < 150; i++) begin
            r1 = rnd64();
            r2 = rnd64();
            r3 = rnd64();
            r4 = rnd64();
            wr(htd_pkg::HTD_SEL_IRQ_FWD, r1);
            wr(htd_pkg::HTD_SEL_INJECT, r2);
            wr(htd_pkg::HTD_SEL_ENABLE, r3);
            @(negedge clock);
            // the model takes the new seed at the next falling edge
            seed <= r4;
            upd <= 1'b1;
            gsel = 6'(r3[35:32] % 9);
            priv = (r4[63:62] == 2'h2) ? 2'h3 : r4[63:62];
            // no virtualised machine mode
            virt = r4[59] && (priv != 2'h3);
            sie = r4[58];
            @(negedge clock);
            upd <= 1'b0;
            repeat (5) @(negedge clock);
            hp = exp_hip(r2 & htd_pkg::INJECT_MASK);
            pend = (sp & se) | (hp & r3 & htd_pkg::ENABLE_MASK);
            ok = priv == 2'h0 || (priv == 2'h1 && (virt || sie));
            eh = exp_host(pend & ~(r1 & htd_pkg::IRQ_FWD_MASK), ok);
            `CHK("host take", eh[6], htake)
            if (eh[6]) `CHK("host code", eh[5:0], hcode)
            v = (pend & r1 & htd_pkg::IRQ_FWD_MASK) >> 1;
            eh = exp_host(v, 1'b1);
            `CHK("guest view", v, gview)
            `CHK("guest pending", eh[6], gpend)
            if (eh[6]) `CHK("guest code", eh[5:0], gcode)
            rd(htd_pkg::HTD_SEL_PENDING, v);
            `CHK("pending", hp, v)
        end
        // synchronous trap forwarding
        for (int i = 0; i < 100; i++) begin
            r1 = rnd64();
            r2 = rnd64();
            if (i == 0) begin
                r1 = '1;
                r2[12:0] = 13'h003F;
            end
            wr(htd_pkg::HTD_SEL_EXC_FWD, r1);
            @(negedge clock);
            tvalid = r2[0] | r2[1];
            tat_host = r2[2] | r2[3];
            tvirt = r2[4] | r2[5];
            tcause = {1'b0, r2[12:8]};
            e = tvalid & tat_host & tvirt & r1[tcause] & EXC_EFF[tcause];
            @(negedge clock);
            tvalid = 1'b0;
            `CHK("trap to guest", e, to_guest)
        end
        tally_and_finish();
    end
endmodule : tb_hyp_trap_delegation_and_virtual_irq
